// ==== ltf_defs.svh ====
// Constants for the link-training frame field block: widths, frame slots,
// field positions, register offsets and reset values.
// Assumes it is included by the package and by every design file.
`ifndef LTF_DEFS_SVH
`define LTF_DEFS_SVH

// Widths
`define LTF_LANES 4
`define LTF_SEED_W 11
`define LTF_FIELD_W 2
`define LTF_WORD_W 16
`define LTF_SLOT_W 5
`define LTF_ADDR_W 12

// Frame slots: marker, control block, status block, then pattern words
`define LTF_SLOT_MARK 5'h00
`define LTF_SLOT_CTRL 5'h01
`define LTF_SLOT_STAT 5'h02
`define LTF_SLOT_LAST 5'h1f
`define LTF_SLOT_ONE 5'h01
`define LTF_MARKER 16'hfff0

// Control block and status block bit positions
`define LTF_CB_PRESET 13
`define LTF_CB_INIT 12
`define LTF_SB_READY 15
`define LTF_F_POST_LSB 4
`define LTF_F_MAIN_LSB 2
`define LTF_F_PRE_LSB 0

// Pattern generator taps and lock-up escape value
`define LTF_PRBS_TAP_A 10
`define LTF_PRBS_TAP_B 8
`define LTF_PRBS_NONZERO 11'h001

// Register byte offsets
`define LTF_REG_CTRL 12'h000
`define LTF_REG_STATUS 12'h004
`define LTF_REG_LANE0 12'h010
`define LTF_LANE_IDX_LSB 2

// Control register fields
`define LTF_CR_EN 0
`define LTF_CR_RESTART 1
`define LTF_CR_PRESET_LSB 4
`define LTF_CR_INIT_LSB 8
`define LTF_CR_RXT_LSB 12

// Lane register fields
`define LTF_LR_SEED_LSB 0
`define LTF_LR_POSTREQ_LSB 16
`define LTF_LR_MAINREQ_LSB 18
`define LTF_LR_PREREQ_LSB 20
`define LTF_LR_POSTST_LSB 24
`define LTF_LR_MAINST_LSB 26
`define LTF_LR_PREST_LSB 28

// Reset values
`define LTF_RST_WORD 16'h0000
`define LTF_RST_DATA 32'h0000_0000
`define LTF_RST_CNT 16'h0000
`define LTF_CNT_ONE 16'h0001

`endif

// ==== ltf_frame_fmt.sv ====
// Builds one lane's outgoing training frame word by word.
// Assumes cfg is stable for the whole frame and slot counts up from zero.
`include "ltf_defs.svh"

module ltf_frame_fmt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic [`LTF_SLOT_W-1:0] slot,
  input wire ltf_pkg::ltf_lane_cfg_t cfg,
  input wire logic [`LTF_SEED_W-1:0] pattern,
  output logic [`LTF_WORD_W-1:0] word_reg
);

  logic [`LTF_WORD_W-1:0] ctrl_word;
  logic [`LTF_WORD_W-1:0] stat_word;

  // Control and status blocks
  always_comb
  begin
    ctrl_word = `LTF_RST_WORD;
    ctrl_word[`LTF_CB_PRESET] = cfg.preset;
    ctrl_word[`LTF_CB_INIT] = cfg.init;
    ctrl_word[`LTF_F_POST_LSB +: `LTF_FIELD_W] = cfg.post_req;
    ctrl_word[`LTF_F_MAIN_LSB +: `LTF_FIELD_W] = cfg.main_req;
    ctrl_word[`LTF_F_PRE_LSB +: `LTF_FIELD_W] = cfg.pre_req;
    stat_word = `LTF_RST_WORD;
    stat_word[`LTF_SB_READY] = cfg.rx_trained;
    stat_word[`LTF_F_POST_LSB +: `LTF_FIELD_W] = cfg.post_stat;
    stat_word[`LTF_F_MAIN_LSB +: `LTF_FIELD_W] = cfg.main_stat;
    stat_word[`LTF_F_PRE_LSB +: `LTF_FIELD_W] = cfg.pre_stat;
  end

  // Word selection by slot; idle lanes send zero words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      word_reg <= `LTF_RST_WORD;
    else if (!active)
      word_reg <= `LTF_RST_WORD;
    else
    begin
      case (slot)
        `LTF_SLOT_MARK: word_reg <= `LTF_MARKER;
        `LTF_SLOT_CTRL: word_reg <= ctrl_word;
        `LTF_SLOT_STAT: word_reg <= stat_word;
        default: word_reg <= {{(`LTF_WORD_W-`LTF_SEED_W){1'b0}}, pattern};
      endcase
    end
  end

endmodule

// ==== ltf_partner.sv ====
// Remote link partner model: decodes the training frames of all four lanes.
// Assumes words and frame_start are sampled on the rising edge of pclk.
`include "ltf_defs.svh"

module ltf_partner (
  input wire logic pclk,
  input wire logic [`LTF_LANES-1:0][`LTF_WORD_W-1:0] lane_tx_word,
  input wire logic frame_start,
  output logic [`LTF_WORD_W-1:0] ctl [`LTF_LANES],
  output logic [`LTF_WORD_W-1:0] st [`LTF_LANES],
  output logic [`LTF_WORD_W-1:0] pat [`LTF_LANES],
  output logic mark_ok,
  output int nfr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`LTF_SLOT_W-1:0] slot = 5'h1f;
  initial mark_ok = 1'b1;
  initial nfr = 0;

  // Slot count parks at the last slot outside frames, so idle words are never decoded
  always @(posedge pclk)
  begin
    slot <= frame_start ? 5'h01 : (slot == 5'h1f ? slot : slot + 5'h01);
    for (int i = 0; i < `LTF_LANES; i++)
    begin
      if (frame_start && lane_tx_word[i] !== `LTF_MARKER)
        mark_ok <= 1'b0;
      if (slot == `LTF_SLOT_CTRL)
        ctl[i] <= lane_tx_word[i];
      if (slot == `LTF_SLOT_STAT)
        st[i] <= lane_tx_word[i];
      if (slot == 5'h03)
        pat[i] <= lane_tx_word[i];
    end
    // A frame counts once its first pattern word has been seen
    if (slot == 5'h03)
      nfr <= nfr + 1;
  end
endmodule

// ==== ltf_pkg.sv ====
// Types shared by the link-training frame field block.
// Assumes ltf_defs.svh is on the include path.
`include "ltf_defs.svh"

package ltf_pkg;

  // Settings for one lane, as carried into one outgoing training frame
  typedef struct packed {
    logic [`LTF_SEED_W-1:0] seed;
    logic [`LTF_FIELD_W-1:0] post_req;
    logic [`LTF_FIELD_W-1:0] main_req;
    logic [`LTF_FIELD_W-1:0] pre_req;
    logic [`LTF_FIELD_W-1:0] post_stat;
    logic [`LTF_FIELD_W-1:0] main_stat;
    logic [`LTF_FIELD_W-1:0] pre_stat;
    logic preset;
    logic init;
    logic rx_trained;
  } ltf_lane_cfg_t;

  // Training controller state
  typedef enum logic [0:0] {
    ltf_st_mission = 1'b0,
    ltf_st_train = 1'b1
  } ltf_state_t;

endpackage

// ==== ltf_prbs.sv ====
// Training pattern generator for one lane: an 11-bit LFSR.
// Assumes load and step come from logic on the same clock.
`include "ltf_defs.svh"

module ltf_prbs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic [`LTF_SEED_W-1:0] seed,
  output logic [`LTF_SEED_W-1:0] state_reg
);

  // An all-zero state would lock the LFSR, so a zero seed is replaced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= `LTF_PRBS_NONZERO;
    else if (load)
      state_reg <= (seed == '0) ? `LTF_PRBS_NONZERO : seed;
    else if (step)
      state_reg <= {state_reg[`LTF_SEED_W-2:0], state_reg[`LTF_PRBS_TAP_A] ^ state_reg[`LTF_PRBS_TAP_B]};
  end

endmodule

// ==== ltf_top.sv ====
// Per-lane training frame field block: takes seeds, coefficient requests
// and coefficient status per lane, and emits training frame words.
// Assumes all user inputs come from logic on pclk; APB master on pclk.
//
// Functional notes
// - Every lane has an 11-bit seed that initialises its pattern generator.
// - Each lane's 2-bit post-tap request goes into the control block of every frame.
// - Each lane's 2-bit main-tap request goes into the control block of every frame.
// - Each lane's 2-bit pre-tap request goes into the control block of every frame.
// - Each lane's 2-bit post-tap status goes into the status block of every frame.
// - Each lane's 2-bit main-tap status goes into the status block of every frame.
// - Each lane's 2-bit pre-tap status goes into the status block of every frame.
// - Settings come from the ports in one build variant and from registers in the other.
// - Per-lane preset and initialize bits are sent in each lane's control block.
// - With training disabled all lanes stay in mission mode and send no frames.
// - A restart pulse restarts training from any state while training is enabled; while training is disabled it is ignored.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "ltf_defs.svh"

module ltf_top #(
  parameter bit REG_VARIANT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`LTF_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic training_enable_input,
  input wire logic training_restart_pulse,
  input wire logic [`LTF_LANES-1:0] preset_bit_per_lane,
  input wire logic [`LTF_LANES-1:0] initialize_bit_per_lane,
  input wire logic [`LTF_LANES-1:0] receiver_trained_per_lane,
  input wire logic [`LTF_SEED_W-1:0] lane0_pattern_seed,
  input wire logic [`LTF_FIELD_W-1:0] lane0_post_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane0_main_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane0_pre_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane0_post_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane0_main_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane0_pre_tap_status,
  input wire logic [`LTF_SEED_W-1:0] lane1_pattern_seed,
  input wire logic [`LTF_FIELD_W-1:0] lane1_post_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane1_main_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane1_pre_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane1_post_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane1_main_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane1_pre_tap_status,
  input wire logic [`LTF_SEED_W-1:0] lane2_pattern_seed,
  input wire logic [`LTF_FIELD_W-1:0] lane2_post_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane2_main_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane2_pre_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane2_post_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane2_main_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane2_pre_tap_status,
  input wire logic [`LTF_SEED_W-1:0] lane3_pattern_seed,
  input wire logic [`LTF_FIELD_W-1:0] lane3_post_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane3_main_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane3_pre_tap_request,
  input wire logic [`LTF_FIELD_W-1:0] lane3_post_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane3_main_tap_status,
  input wire logic [`LTF_FIELD_W-1:0] lane3_pre_tap_status,
  output logic [`LTF_LANES-1:0][`LTF_WORD_W-1:0] lane_tx_word,
  output logic training_active,
  output logic frame_start
);

  ltf_pkg::ltf_lane_cfg_t port_cfg [`LTF_LANES];
  ltf_pkg::ltf_lane_cfg_t reg_cfg [`LTF_LANES];
  ltf_pkg::ltf_lane_cfg_t sel_cfg [`LTF_LANES];
  ltf_pkg::ltf_lane_cfg_t snap_reg [`LTF_LANES];
  logic [`LTF_SEED_W-1:0] pattern [`LTF_LANES];
  logic [31:0] lane_reg [`LTF_LANES];
  logic [31:0] ctrl_reg;
  logic restart_reg;
  logic [15:0] frames_reg;
  logic [31:0] rd_data;
  logic addr_ok;
  logic [`LTF_LANES-1:0] lane_hit;
  ltf_pkg::ltf_state_t state_reg;
  logic [`LTF_SLOT_W-1:0] slot_reg;
  logic sel_en;
  logic sel_restart;
  logic start_train;
  logic is_train;
  logic setup;
  logic wr_done;

  // Direct port settings gathered per lane
  assign port_cfg[0] = {lane0_pattern_seed, lane0_post_tap_request, lane0_main_tap_request,
    lane0_pre_tap_request, lane0_post_tap_status, lane0_main_tap_status, lane0_pre_tap_status,
    preset_bit_per_lane[0], initialize_bit_per_lane[0], receiver_trained_per_lane[0]};
  assign port_cfg[1] = {lane1_pattern_seed, lane1_post_tap_request, lane1_main_tap_request,
    lane1_pre_tap_request, lane1_post_tap_status, lane1_main_tap_status, lane1_pre_tap_status,
    preset_bit_per_lane[1], initialize_bit_per_lane[1], receiver_trained_per_lane[1]};
  assign port_cfg[2] = {lane2_pattern_seed, lane2_post_tap_request, lane2_main_tap_request,
    lane2_pre_tap_request, lane2_post_tap_status, lane2_main_tap_status, lane2_pre_tap_status,
    preset_bit_per_lane[2], initialize_bit_per_lane[2], receiver_trained_per_lane[2]};
  assign port_cfg[3] = {lane3_pattern_seed, lane3_post_tap_request, lane3_main_tap_request,
    lane3_pre_tap_request, lane3_post_tap_status, lane3_main_tap_status, lane3_pre_tap_status,
    preset_bit_per_lane[3], initialize_bit_per_lane[3], receiver_trained_per_lane[3]};

  // Enable and restart source chosen by build variant
  // variant source select
  assign sel_en = REG_VARIANT ? ctrl_reg[`LTF_CR_EN] : training_enable_input;
  assign sel_restart = REG_VARIANT ? restart_reg : training_restart_pulse;
  assign is_train = (state_reg == ltf_pkg::ltf_st_train);
  assign start_train = sel_en && (sel_restart || !is_train);

  // Training controller: mission mode whenever enable is low
  // disable forces mission
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ltf_pkg::ltf_st_mission;
    else if (sel_en)
      state_reg <= ltf_pkg::ltf_st_train;
    else
      state_reg <= ltf_pkg::ltf_st_mission;
  end

  // Frame slot counter, rewound on every start or restart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slot_reg <= `LTF_SLOT_MARK;
    else if (start_train || !sel_en)
      slot_reg <= `LTF_SLOT_MARK;
    else if (slot_reg == `LTF_SLOT_LAST)
      slot_reg <= `LTF_SLOT_MARK;
    else
      slot_reg <= slot_reg + `LTF_SLOT_ONE;
  end

  // Output flags aligned with the formatter's registered word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      training_active <= 1'b0;
      frame_start <= 1'b0;
    end
    else
    begin
      training_active <= is_train;
      frame_start <= is_train && (slot_reg == `LTF_SLOT_MARK);
    end
  end

  // Frames sent, visible in the status register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frames_reg <= `LTF_RST_CNT;
    else if (is_train && (slot_reg == `LTF_SLOT_MARK))
      frames_reg <= frames_reg + `LTF_CNT_ONE;
  end

  // Per-lane datapath
  generate
    for (genvar i = 0; i < `LTF_LANES; i++)
    begin : g_lane
      // Register-variant settings unpacked from the lane word and control word
      assign reg_cfg[i] = {lane_reg[i][`LTF_LR_SEED_LSB +: `LTF_SEED_W],
        lane_reg[i][`LTF_LR_POSTREQ_LSB +: `LTF_FIELD_W], lane_reg[i][`LTF_LR_MAINREQ_LSB +: `LTF_FIELD_W],
        lane_reg[i][`LTF_LR_PREREQ_LSB +: `LTF_FIELD_W], lane_reg[i][`LTF_LR_POSTST_LSB +: `LTF_FIELD_W],
        lane_reg[i][`LTF_LR_MAINST_LSB +: `LTF_FIELD_W], lane_reg[i][`LTF_LR_PREST_LSB +: `LTF_FIELD_W],
        ctrl_reg[`LTF_CR_PRESET_LSB + i], ctrl_reg[`LTF_CR_INIT_LSB + i], ctrl_reg[`LTF_CR_RXT_LSB + i]};
      assign sel_cfg[i] = REG_VARIANT ? reg_cfg[i] : port_cfg[i];

      // One snapshot per frame keeps every field of a frame consistent
      // sample at frame start
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          snap_reg[i] <= '0;
        else if (is_train && (slot_reg == `LTF_SLOT_MARK))
          snap_reg[i] <= sel_cfg[i];
      end

      ltf_prbs u_prbs (
        .pclk(pclk),
        .presetn(presetn),
        .load(start_train),
        .step(is_train && (slot_reg > `LTF_SLOT_STAT)),
        .seed(sel_cfg[i].seed),
        .state_reg(pattern[i])
      );

      ltf_frame_fmt u_fmt (
        .pclk(pclk),
        .presetn(presetn),
        .active(is_train),
        .slot(slot_reg),
        .cfg(snap_reg[i]),
        .pattern(pattern[i]),
        .word_reg(lane_tx_word[i])
      );

      // Lane register writes; ignored by the datapath in the port variant
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          lane_reg[i] <= `LTF_RST_DATA;
        else if (wr_done && lane_hit[i])
          lane_reg[i] <= pwdata;
      end
      assign lane_hit[i] = (paddr == (`LTF_REG_LANE0 + (`LTF_ADDR_W)'(i << `LTF_LANE_IDX_LSB)));
    end
  endgenerate

  // APB decode; access phase always completes in its first cycle
  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign addr_ok = (paddr == `LTF_REG_CTRL) || (paddr == `LTF_REG_STATUS) || (|lane_hit);

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_data = `LTF_RST_DATA;
    if (paddr == `LTF_REG_CTRL)
      rd_data = ctrl_reg;
    else if (paddr == `LTF_REG_STATUS)
      rd_data = {frames_reg, 15'h0000, is_train};
    else
    begin
      for (int k = 0; k < `LTF_LANES; k++)
        if (lane_hit[k])
          rd_data = lane_reg[k];
    end
  end

  // Bus answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= `LTF_RST_DATA;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_data : `LTF_RST_DATA;
      pslverr <= setup && !addr_ok;
    end
  end

  // Control register; restart bit is a write-one pulse, never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `LTF_RST_DATA;
      restart_reg <= 1'b0;
    end
    else
    begin
      restart_reg <= wr_done && (paddr == `LTF_REG_CTRL) && pwdata[`LTF_CR_RESTART];
      if (wr_done && (paddr == `LTF_REG_CTRL))
      begin
        ctrl_reg <= pwdata;
        ctrl_reg[`LTF_CR_RESTART] <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_mission_quiet;
    !sel_en |=> !is_train ##1 (lane_tx_word == '0) && !frame_start;
  endproperty
  a_mission_quiet: assert property (p_mission_quiet) else $error("Frame words sent while training disabled");

  property p_restart;
    sel_en && sel_restart |=> is_train && (slot_reg == `LTF_SLOT_MARK) ##1 frame_start;
  endproperty
  a_restart: assert property (p_restart) else $error("Restart did not rewind the frame");

  property p_seed_load;
    start_train && (sel_cfg[1].seed != '0) |=> pattern[1] == $past(sel_cfg[1].seed);
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("Lane 1 seed not loaded");

  property p_seed_restart;
    start_train && is_train && (sel_cfg[2].seed != '0) |=> pattern[2] == $past(sel_cfg[2].seed);
  endproperty
  a_seed_restart: assert property (p_seed_restart) else $error("Seed not reloaded on restart");

  property p_snapshot;
    // A new snapshot may only land where frame_start shows, so a restart is no false alarm
    is_train && (slot_reg == `LTF_SLOT_MARK) |=> (snap_reg[2] == $past(sel_cfg[2]))
      ##1 (frame_start || $stable(snap_reg[2]))[*8];
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("Frame settings not held for the frame");

  sequence s_ctrl_slot;
    is_train && (slot_reg == `LTF_SLOT_CTRL) && !start_train;
  endsequence

  sequence s_stat_slot;
    is_train && (slot_reg == `LTF_SLOT_STAT) && !start_train;
  endsequence

  property p_post_req;
    s_ctrl_slot |=> lane_tx_word[0][`LTF_F_POST_LSB +: `LTF_FIELD_W] == $past(snap_reg[0].post_req);
  endproperty
  a_post_req: assert property (p_post_req) else $error("Post-tap request field wrong");

  property p_main_req;
    s_ctrl_slot |=> lane_tx_word[1][`LTF_F_MAIN_LSB +: `LTF_FIELD_W] == $past(snap_reg[1].main_req);
  endproperty
  a_main_req: assert property (p_main_req) else $error("Main-tap request field wrong");

  property p_pre_req;
    s_ctrl_slot |=> lane_tx_word[2][`LTF_F_PRE_LSB +: `LTF_FIELD_W] == $past(snap_reg[2].pre_req);
  endproperty
  a_pre_req: assert property (p_pre_req) else $error("Pre-tap request field wrong");

  property p_preset_init;
    s_ctrl_slot |=> lane_tx_word[3][`LTF_CB_PRESET] == $past(snap_reg[3].preset)
      && lane_tx_word[3][`LTF_CB_INIT] == $past(snap_reg[3].init);
  endproperty
  a_preset_init: assert property (p_preset_init) else $error("Preset or initialize bit wrong");

  property p_post_stat;
    s_stat_slot |=> lane_tx_word[0][`LTF_F_POST_LSB +: `LTF_FIELD_W] == $past(snap_reg[0].post_stat);
  endproperty
  a_post_stat: assert property (p_post_stat) else $error("Post-tap status field wrong");

  property p_main_stat;
    s_stat_slot |=> lane_tx_word[1][`LTF_F_MAIN_LSB +: `LTF_FIELD_W] == $past(snap_reg[1].main_stat);
  endproperty
  a_main_stat: assert property (p_main_stat) else $error("Main-tap status field wrong");

  property p_pre_stat;
    s_stat_slot |=> lane_tx_word[3][`LTF_F_PRE_LSB +: `LTF_FIELD_W] == $past(snap_reg[3].pre_stat);
  endproperty
  a_pre_stat: assert property (p_pre_stat) else $error("Pre-tap status field wrong");

  c_frame: cover property (frame_start ##1 !frame_start [*8]);
  c_restart_mid: cover property (is_train && (slot_reg > `LTF_SLOT_STAT) && sel_restart);
  c_disable: cover property (is_train ##1 !sel_en);
  c_bus_err: cover property (pslverr && pready);

endmodule

// ==== ltf_top_tb_top.sv ====
// Testbench for the training frame field block, port variant.
// Assumes ltf_partner decodes the frames; APB master is this bench.
`include "ltf_defs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module ltf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic en = 1'b0;
  logic rst_p = 1'b0;
  logic [3:0] pr = 4'h0;
  logic [3:0] ini = 4'h0;
  logic [3:0] rxt = 4'h0;
  logic [10:0] sd [4] = '{11'h5a5, 11'h3c3, 11'h001, 11'h7ff};
  logic [11:0] f [4] = '{12'h1b6, 12'he49, 12'h72d, 12'h8d2};
  logic [3:0][15:0] lane_tx_word;
  logic training_active;
  logic frame_start;
  logic [15:0] ctl [4];
  logic [15:0] st [4];
  logic [15:0] pat [4];
  logic mark_ok;
  int nfr;
  int err_total = 0;
  int n_checks = 0;

  // Half period of 25 ns gives 20 MHz
  always #25 pclk = ~pclk;

  ltf_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .training_enable_input(en), .training_restart_pulse(rst_p), .preset_bit_per_lane(pr),
    .initialize_bit_per_lane(ini), .receiver_trained_per_lane(rxt),
    .lane0_pattern_seed(sd[0]), .lane0_post_tap_request(f[0][11:10]), .lane0_main_tap_request(f[0][9:8]),
    .lane0_pre_tap_request(f[0][7:6]), .lane0_post_tap_status(f[0][5:4]), .lane0_main_tap_status(f[0][3:2]),
    .lane0_pre_tap_status(f[0][1:0]),
    .lane1_pattern_seed(sd[1]), .lane1_post_tap_request(f[1][11:10]), .lane1_main_tap_request(f[1][9:8]),
    .lane1_pre_tap_request(f[1][7:6]), .lane1_post_tap_status(f[1][5:4]), .lane1_main_tap_status(f[1][3:2]),
    .lane1_pre_tap_status(f[1][1:0]),
    .lane2_pattern_seed(sd[2]), .lane2_post_tap_request(f[2][11:10]), .lane2_main_tap_request(f[2][9:8]),
    .lane2_pre_tap_request(f[2][7:6]), .lane2_post_tap_status(f[2][5:4]), .lane2_main_tap_status(f[2][3:2]),
    .lane2_pre_tap_status(f[2][1:0]),
    .lane3_pattern_seed(sd[3]), .lane3_post_tap_request(f[3][11:10]), .lane3_main_tap_request(f[3][9:8]),
    .lane3_pre_tap_request(f[3][7:6]), .lane3_post_tap_status(f[3][5:4]), .lane3_main_tap_status(f[3][3:2]),
    .lane3_pre_tap_status(f[3][1:0]),
    .lane_tx_word(lane_tx_word), .training_active(training_active), .frame_start(frame_start));

  ltf_partner lp (.pclk(pclk), .lane_tx_word(lane_tx_word), .frame_start(frame_start), .ctl(ctl),
    .st(st), .pat(pat), .mark_ok(mark_ok), .nfr(nfr));

  // Expected words, built from the bench's own inputs
  function automatic logic [15:0] ectl(int i);
    return {2'b00, pr[i], ini[i], 6'h00, f[i][11:6]};
  endfunction
  function automatic logic [15:0] est(int i);
    return {rxt[i], 9'h000, f[i][5:0]};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait for n more decoded frames; a hang ends the run
  task automatic wait_frames(int n);
    int t;
    t = nfr + n;
    for (int k = 0; k < 100 * n && nfr < t; k++)
      @(posedge pclk);
    `CHK(nfr >= t, 1'b1)
    if (nfr < t)
      results();
  endtask

  // One APB transfer, entered just after an edge; waits for pready, not for a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      results();
    end
    @(posedge pclk);
  endtask

  // Bounded wait for the next frame_start; a hang ends the run
  task automatic wait_fs();
    for (int k = 0; k < 40 && frame_start !== 1'b1; k++)
      @(posedge pclk);
    `CHK(frame_start, 1'b1)
    if (frame_start !== 1'b1)
      results();
  endtask

  // Disabled: no frames, zero words, a restart is ignored
  task automatic s_mission();
    logic bad;
    bad = 1'b0;
    repeat (2) @(posedge pclk);
    rst_p <= 1'b1;
    @(posedge pclk);
    rst_p <= 1'b0;
    repeat (40)
    begin
      @(posedge pclk);
      bad = bad | (frame_start !== 1'b0) | (training_active !== 1'b0) | (lane_tx_word !== '0);
    end
    `CHK(bad, 1'b0)
  endtask

  // Every lane carries its own fields, bits and seed
  task automatic s_fields();
    pr <= 4'b1010;
    ini <= 4'b0110;
    rxt <= 4'b1100;
    en <= 1'b1;
    // First frame only: later frames carry a stepped pattern word
    wait_frames(1);
    for (int i = 0; i < 4; i++)
    begin
      `CHK(ctl[i], ectl(i))
      `CHK(st[i], est(i))
      `CHK(pat[i], {5'h00, sd[i]})
    end
    `CHK(mark_ok, 1'b1)
    `CHK(training_active, 1'b1)
  endtask

  // Inputs changed right after the snapshot show up one frame later
  task automatic s_snapshot();
    logic [15:0] oc [4];
    wait_fs();
    for (int i = 0; i < 4; i++)
      oc[i] = ectl(i);
    for (int i = 0; i < 4; i++)
      f[i] <= ~f[i];
    pr <= ~pr;
    rxt <= ~rxt;
    wait_frames(1);
    for (int i = 0; i < 4; i++)
      `CHK(ctl[i], oc[i])
    wait_frames(1);
    for (int i = 0; i < 4; i++)
      `CHK(st[i], est(i))
  endtask

  // Restart mid-frame rewinds at once and reloads the new seeds
  task automatic s_restart();
    wait_fs();
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 4; i++)
      sd[i] <= ~sd[i];
    rst_p <= 1'b1;
    @(posedge pclk);
    rst_p <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(frame_start, 1'b1)
    wait_frames(1);
    for (int i = 0; i < 4; i++)
      `CHK(pat[i], (sd[i] == 11'h000) ? 16'h0001 : {5'h00, sd[i]})
  endtask

  // Registers store and read back but do not steer the port variant
  task automatic s_apb();
    logic [31:0] q;
    logic e;
    apb(1'b1, 12'h018, 32'ha5a5_5a5a, q, e);
    apb(1'b0, 12'h018, 32'h0000_0000, q, e);
    `CHK(q, 32'ha5a5_5a5a)
    apb(1'b0, 12'h100, 32'h0000_0000, q, e);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    apb(1'b0, 12'h004, 32'h0000_0000, q, e);
    `CHK(q[0], 1'b1)
    wait_frames(1);
    `CHK(ctl[2], ectl(2))
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_mission();
    s_fields();
    s_snapshot();
    s_restart();
    s_apb();
    en <= 1'b0;
    s_mission();
    results();
  end
endmodule
